/* rpis_pkg.sv */
// package: register map, field layout and constants of the remappable input pin select
package rpis_pkg;
    // ==========================================================
    // geometry
    localparam int          RPIS_PIN_MAX    = 26;
    localparam int          RPIS_SEL_W      = 5;
    localparam int          RPIS_NUM_REG    = 24;
    localparam int          RPIS_NUM_FUNC   = 23;
    // ==========================================================
    // register index and byte addresses (byte address is index times four)
    localparam logic [7:0]  RPIS_IDX_UNLOCK = 8'h20;
    localparam logic [9:0]  RPIS_OFF_ROUTE  = 10'h000;
    localparam logic [9:0]  RPIS_OFF_OSCCTL = 10'h080;
    localparam logic [9:0]  RPIS_OFF_STATUS = 10'h084;
    // ==========================================================
    // field positions and reset values
    localparam int          RPIS_LO_POS     = 0;
    localparam int          RPIS_HI_POS     = 8;
    localparam int          RPIS_LOCK_POS   = 6;
    localparam logic [4:0]  RPIS_SEL_RST    = 5'h1f;
    localparam logic [7:0]  RPIS_KEY_ONE    = 8'h46;
    localparam logic [7:0]  RPIS_KEY_TWO    = 8'h57;
    localparam logic        RPIS_LOCK_RST   = 1'b0;
    localparam logic        RPIS_IDLE_LEVEL = 1'b0;
    // ==========================================================
    // unlock sequence states
    typedef enum logic [1:0] {
        RPIS_KEY_WAIT,
        RPIS_KEY_HALF,
        RPIS_KEY_OPEN
    } rpis_key_t;
    // ==========================================================
    // map of each routed function to its register index and half
    typedef logic [4:0] rpis_reg_idx_t;
    localparam rpis_reg_idx_t RPIS_FUNC_REG [RPIS_NUM_FUNC] = '{
        5'h00, 5'h01, 5'h03, 5'h03, 5'h04, 5'h04, 5'h07, 5'h07, 5'h08, 5'h08,
        5'h09, 5'h0b, 5'h0b, 5'h12, 5'h12, 5'h13, 5'h13, 5'h14, 5'h14, 5'h15,
        5'h16, 5'h16, 5'h17};
    localparam logic [RPIS_NUM_FUNC-1:0] RPIS_FUNC_HI = 23'h2552a8;
endpackage : rpis_pkg

/* rpis_sync.sv */
// two-flop synchroniser bank for the remappable pins
module rpis_sync #(
    parameter int W = 26
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_b,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    // ==========================================================
    // stage one feeds stage two only
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : rpis_sync

/* rpis_top.sv */
// remappable input pin select: ahb-lite register file, lock and input routing
// ==========================================================
// Overview of operation
// - up to 26 remappable pins, numbered
// - each peripheral input's selector picks its pin
// - two 5-bit selectors per routing register
// - valid selector range matches pin count
// - interrupt, timer, capture, fault selector placement
// - uart and spi selector placement
// - input routing registers separate from output
// - routed functions are purely digital
// - i2c, notification, alarm, analog stay fixed
// - no default pin until software assigns
// - remapped input owns pin over digital
// - analog function always keeps pin priority
// - routing changes by runtime register writes
// - safeguards block spurious routing changes
// - reset loads all ones, pin 31
// - locked writes complete but change nothing
// - lock changes only after 46h, 57h
// - shadow compare raises mismatch reset request
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
module rpis_top
    import rpis_pkg::*;
#(
    parameter int PIN_CNT = RPIS_PIN_MAX
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // remappable pins and their analog claim
    input  wire logic [25:0] remappable_pin_number,
    input  wire logic [25:0] pin_analog_sel,
    // routed peripheral inputs
    output logic             ext_irq_one_input,
    output logic             ext_irq_two_input,
    output logic             timer_two_ext_clock,
    output logic             timer_three_ext_clock,
    output logic             timer_four_ext_clock,
    output logic             timer_five_ext_clock,
    output logic             capture_one_input,
    output logic             capture_two_input,
    output logic             capture_three_input,
    output logic             capture_four_input,
    output logic             capture_five_input,
    output logic             compare_fault_a_input,
    output logic             compare_fault_b_input,
    output logic             serial_one_receive,
    output logic             serial_one_clear_to_send,
    output logic             serial_two_receive,
    output logic             serial_two_clear_to_send,
    output logic             spi_one_data_in,
    output logic             spi_one_clock_in,
    output logic             spi_one_select_in,
    output logic             spi_two_data_in,
    output logic             spi_two_clock_in,
    output logic             spi_two_select_in,
    // state
    output logic             mapping_lock_bit,
    output logic             mismatch_reset_req
);
    initial begin
        if (PIN_CNT < 1 || PIN_CNT > RPIS_PIN_MAX) begin
            $error("rpis_top: PIN_CNT out of range");
        end
        // the reset code must name no real pin, or inputs would be routed from reset
        if (int'(RPIS_SEL_RST) < PIN_CNT) begin
            $error("rpis_top: reset selector names a real pin");
        end
        if (RPIS_SEL_W < $clog2(PIN_CNT + 1)) begin
            $error("rpis_top: selector field too narrow for PIN_CNT");
        end
    end

    // ==========================================================
    // register file storage
    logic [RPIS_SEL_W-1:0] sel_lo_r     [RPIS_NUM_REG];
    logic [RPIS_SEL_W-1:0] sel_hi_r     [RPIS_NUM_REG];
    logic [RPIS_SEL_W-1:0] shadow_lo_r  [RPIS_NUM_REG];
    logic [RPIS_SEL_W-1:0] shadow_hi_r  [RPIS_NUM_REG];
    logic [RPIS_NUM_REG-1:0] reg_present;
    logic [7:0]            osc_low_r;
    rpis_key_t             key_r;
    logic [25:0]           pin_sync;
    logic [RPIS_NUM_FUNC-1:0] route_val;
    logic [RPIS_NUM_FUNC-1:0] route_r;

    // only the documented routing registers exist, the rest of the block is holes
    always_comb begin
        reg_present = '0;
        for (int f = 0; f < RPIS_NUM_FUNC; f++) begin
            reg_present[RPIS_FUNC_REG[f]] = 1'b1;
        end
    end

    // ==========================================================
    // ahb-lite address phase capture
    logic        dp_wr_r;
    logic        dp_rd_r;
    logic [9:0]  dp_addr_r;
    logic        ap_valid;

    // nothing is taken while ready is low, so the read wait state holds off the next one
    assign ap_valid = hsel && hready && htrans[1];

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dp_wr_r   <= 1'b0;
            dp_rd_r   <= 1'b0;
            dp_addr_r <= '0;
        end else begin
            dp_wr_r   <= ap_valid && hwrite;
            dp_rd_r   <= ap_valid && !hwrite;
            dp_addr_r <= ap_valid ? haddr[9:0] : dp_addr_r;
        end
    end

    // reads take one wait state so hrdata can leave a flop; writes land with none
    // the response is always okay
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= !(ap_valid && !hwrite);
            hresp     <= 1'b0;
        end
    end

    // ==========================================================
    // data phase decode
    logic                route_hit;
    logic [4:0]          route_idx;
    logic                osc_hit;
    logic                stat_hit;
    logic                idx_ok;

    // indices past the last register would reach outside the selector arrays
    assign idx_ok    = int'(route_idx) < RPIS_NUM_REG;
    assign route_idx = dp_addr_r[6:2];
    assign route_hit = (dp_addr_r[9:7] == RPIS_OFF_ROUTE[9:7]) && (dp_addr_r[1:0] == 2'b00)
                       && idx_ok && reg_present[route_idx];
    assign osc_hit   = (dp_addr_r == RPIS_OFF_OSCCTL);
    assign stat_hit  = (dp_addr_r == RPIS_OFF_STATUS);

    // ==========================================================
    // unlock key sequence on the oscillator control low byte
    logic key_step_one;
    logic key_step_two;
    logic lock_write;

    assign key_step_one = dp_wr_r && osc_hit && (hwdata[7:0] == RPIS_KEY_ONE);
    assign key_step_two = dp_wr_r && osc_hit && (hwdata[7:0] == RPIS_KEY_TWO);

    // the lock may only move on the write right after the second key
    assign lock_write = dp_wr_r && osc_hit && (key_r == RPIS_KEY_OPEN);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            key_r <= RPIS_KEY_WAIT;
        end else begin
            unique case (key_r)
                RPIS_KEY_WAIT: key_r <= key_step_one ? RPIS_KEY_HALF : RPIS_KEY_WAIT;
                RPIS_KEY_HALF: begin
                    if (dp_wr_r) begin
                        key_r <= key_step_two ? RPIS_KEY_OPEN : RPIS_KEY_WAIT;
                    end
                end
                RPIS_KEY_OPEN: begin
                    if (dp_wr_r) begin
                        key_r <= RPIS_KEY_WAIT;
                    end
                end
                // the spare code falls back to waiting for the first key
                default: key_r <= RPIS_KEY_WAIT;
            endcase
        end
    end

    // lock holds its state until a keyed write changes it
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mapping_lock_bit <= RPIS_LOCK_RST;
        end else if (lock_write) begin
            mapping_lock_bit <= hwdata[RPIS_LOCK_POS];
        end
    end

    // remaining low byte bits are plain storage, the key bytes are not kept
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            osc_low_r <= '0;
        end else if (dp_wr_r && osc_hit && !key_step_one && !key_step_two) begin
            osc_low_r <= hwdata[7:0];
        end
    end

    // ==========================================================
    // routing selectors and their shadows
    logic route_we;

    // locked writes are accepted on the bus but dropped here
    assign route_we = dp_wr_r && route_hit && !mapping_lock_bit;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (int r = 0; r < RPIS_NUM_REG; r++) begin
                sel_lo_r[r]    <= RPIS_SEL_RST;
                sel_hi_r[r]    <= RPIS_SEL_RST;
                shadow_lo_r[r] <= RPIS_SEL_RST;
                shadow_hi_r[r] <= RPIS_SEL_RST;
            end
        end else if (route_we) begin
            sel_lo_r[route_idx]    <= hwdata[RPIS_LO_POS +: RPIS_SEL_W];
            sel_hi_r[route_idx]    <= hwdata[RPIS_HI_POS +: RPIS_SEL_W];
            shadow_lo_r[route_idx] <= hwdata[RPIS_LO_POS +: RPIS_SEL_W];
            shadow_hi_r[route_idx] <= hwdata[RPIS_HI_POS +: RPIS_SEL_W];
        end
    end

    // continuous shadow compare, latched until reset
    logic mismatch;

    always_comb begin
        mismatch = 1'b0;
        for (int r = 0; r < RPIS_NUM_REG; r++) begin
            if (reg_present[r] &&
                (sel_lo_r[r] != shadow_lo_r[r] || sel_hi_r[r] != shadow_hi_r[r])) begin
                mismatch = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mismatch_reset_req <= 1'b0;
        end else if (mismatch) begin
            mismatch_reset_req <= 1'b1;
        end
    end

    // ==========================================================
    // read data
    logic [31:0] rd_word;

    always_comb begin
        rd_word = '0;
        if (route_hit) begin
            rd_word = {19'h0, sel_hi_r[route_idx], 3'h0, sel_lo_r[route_idx]};
        end else if (osc_hit) begin
            rd_word = {24'h0, osc_low_r[7], mapping_lock_bit, osc_low_r[5:0]};
        end else if (stat_hit) begin
            rd_word = {29'h0, mismatch_reset_req, key_r};
        end
    end

    // the word stands only in the cycle after the wait state, zero otherwise
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hrdata <= '0;
        end else begin
            hrdata <= dp_rd_r ? rd_word : 32'h0;
        end
    end

    // ==========================================================
    // pin synchroniser
    rpis_sync #(
        .W (26)
    ) u_sync (
        .mclk  (mclk),
        .rst_b (rst_b),
        .d     (remappable_pin_number),
        .q     (pin_sync)
    );

    // ==========================================================
    // per function pin select
    // this block only routes inputs; output mapping lives in a separate register set
    // all-ones reset codes and pins past the count fall to the idle level
    genvar g;
    generate
        for (g = 0; g < RPIS_NUM_FUNC; g++) begin : g_route
            logic [RPIS_SEL_W-1:0] sel;
            assign sel = RPIS_FUNC_HI[g] ? sel_hi_r[RPIS_FUNC_REG[g]]
                                         : sel_lo_r[RPIS_FUNC_REG[g]];
            always_comb begin
                if (int'(sel) >= PIN_CNT) begin
                    route_val[g] = RPIS_IDLE_LEVEL;
                end else if (pin_analog_sel[sel]) begin
                    route_val[g] = RPIS_IDLE_LEVEL;
                end else begin
                    route_val[g] = pin_sync[sel];
                end
            end
        end
    endgenerate

    // i2c, notification and alarm paths never pass through here
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            route_r <= '0;
        end else begin
            route_r <= route_val;
        end
    end

    assign ext_irq_one_input        = route_r[0];
    assign ext_irq_two_input        = route_r[1];
    assign timer_two_ext_clock      = route_r[2];
    assign timer_three_ext_clock    = route_r[3];
    assign timer_four_ext_clock     = route_r[4];
    assign timer_five_ext_clock     = route_r[5];
    assign capture_one_input        = route_r[6];
    assign capture_two_input        = route_r[7];
    assign capture_three_input      = route_r[8];
    assign capture_four_input       = route_r[9];
    assign capture_five_input       = route_r[10];
    assign compare_fault_a_input    = route_r[11];
    assign compare_fault_b_input    = route_r[12];
    assign serial_one_receive       = route_r[13];
    assign serial_one_clear_to_send = route_r[14];
    assign serial_two_receive       = route_r[15];
    assign serial_two_clear_to_send = route_r[16];
    assign spi_one_data_in          = route_r[17];
    assign spi_one_clock_in         = route_r[18];
    assign spi_one_select_in        = route_r[19];
    assign spi_two_data_in          = route_r[20];
    assign spi_two_clock_in         = route_r[21];
    assign spi_two_select_in        = route_r[22];
endmodule : rpis_top

/* rpis_pin_model.sv */
// partner model: external digital devices driving the remappable pins
module rpis_pin_model (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // wanted levels and the pins themselves
    input  wire logic [25:0] pin_want,
    output logic      [25:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // pins move just after an edge, so the synchroniser sees clean steps
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pins <= 26'h3ffffff;
        end else begin
            pins <= pin_want;
        end
    end
endmodule : rpis_pin_model

/* rpis_top_sva.sv */
// checker: bus, lock and routing relations at the ports of rpis_top
module rpis_top_sva
    import rpis_pkg::*;
#(
    parameter int PIN_CNT = RPIS_PIN_MAX
) (
    // clock, reset and bus
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // pins, routed inputs and state
    input wire logic [25:0] pin_analog_sel,
    input wire logic        ext_irq_one_input,
    input wire logic        spi_two_select_in,
    input wire logic        mapping_lock_bit,
    input wire logic        mismatch_reset_req
);
    logic       rd_ph_r;
    logic       rd_dat_r;
    logic       osc_ph_r;
    logic [9:0] ra_r;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // data phase trackers; reads wait one cycle, then the word stands for one
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rd_ph_r  <= 1'b0;
            rd_dat_r <= 1'b0;
            osc_ph_r <= 1'b0;
            ra_r     <= 10'h000;
        end else begin
            rd_ph_r  <= hsel && hready && htrans[1] && !hwrite;
            rd_dat_r <= rd_ph_r;
            osc_ph_r <= hsel && hready && htrans[1] && hwrite && haddr[9:0] == RPIS_OFF_OSCCTL;
            if (hsel && hready && htrans[1]) begin
                ra_r <= haddr[9:0];
            end
        end
    end
    // ==========================================================
    // properties
    sequence s_taken_wr;
        hsel && hready && htrans[1] && hwrite;
    endsequence
    sequence s_taken_rd;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence s_rd_stall;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence s_rd_route;
        rd_dat_r && ra_r < 10'h060;
    endsequence
    property p_ack;
        s_taken_wr |=> hreadyout;
    endproperty
    property p_rd_wait;
        s_taken_rd |=> s_rd_stall;
    endproperty
    property p_okay;
        hresp == 1'b0;
    endproperty
    property p_rd_idle;
        !rd_dat_r |-> hrdata == 32'h0;
    endproperty
    property p_rd_pack;
        s_rd_route |-> (hrdata & 32'hffffe0e0) == 32'h0;
    endproperty
    property p_lock_src;
        $changed(mapping_lock_bit) |-> $past(osc_ph_r);
    endproperty
    property p_lock_val;
        $changed(mapping_lock_bit) |-> mapping_lock_bit == $past(hwdata[RPIS_LOCK_POS]);
    endproperty
    property p_analog;
        &pin_analog_sel |=> !ext_irq_one_input && !spi_two_select_in;
    endproperty
    property p_rst_state;
        $rose(rst_b) |-> !ext_irq_one_input && !spi_two_select_in && !mapping_lock_bit;
    endproperty
    property p_no_mm;
        !mismatch_reset_req;
    endproperty
    a_ack: assert property (p_ack) else $error("no ready after transfer");
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state missing");
    a_okay: assert property (p_okay) else $error("error response seen");
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
    a_rd_pack: assert property (p_rd_pack) else $error("bad route word layout");
    a_lock_src: assert property (p_lock_src) else $error("lock moved without write");
    a_lock_val: assert property (p_lock_val) else $error("lock took wrong value");
    a_analog: assert property (p_analog) else $error("routed input beat analog");
    a_rst_state: assert property (p_rst_state) else $error("bad state after reset");
    a_no_mm: assert property (p_no_mm) else $error("spurious mismatch request");
endmodule : rpis_top_sva

bind rpis_top rpis_top_sva #(.PIN_CNT(PIN_CNT)) u_sva (
    .mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pin_analog_sel(pin_analog_sel),
    .ext_irq_one_input(ext_irq_one_input), .spi_two_select_in(spi_two_select_in),
    .mapping_lock_bit(mapping_lock_bit), .mismatch_reset_req(mismatch_reset_req)
);

/* remappable_input_pin_select_bench.sv */
// bench: routing table, reset, boundary, analog, lock and second reset cases
module remappable_input_pin_select_bench;
    import rpis_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, rst_b, hsel, hwrite, hreadyout, hresp, lock, mm;
    logic [31:0] haddr, hwdata, hrdata, rd, a, wd;
    logic [1:0]  htrans;
    logic [25:0] pin_want, pins, ana;
    logic [22:0] outs;
    logic [4:0]  p;
    int          error_cnt, checks_done;
    // ==========================================================
    // rows: register of each routed input, and whether it is the high half
    localparam logic [4:0] FN_REG [23] = '{5'h00, 5'h01, 5'h03, 5'h03, 5'h04, 5'h04,
        5'h07, 5'h07, 5'h08, 5'h08, 5'h09, 5'h0b, 5'h0b, 5'h12, 5'h12, 5'h13, 5'h13,
        5'h14, 5'h14, 5'h15, 5'h16, 5'h16, 5'h17};
    localparam logic [22:0] FN_HI = 23'b01001010101001010101000;
    rpis_pin_model pm (.mclk(mclk), .rst_b(rst_b), .pin_want(pin_want), .pins(pins));
    rpis_top #(.PIN_CNT(26)) dut (
        .mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .remappable_pin_number(pins), .pin_analog_sel(ana),
        .ext_irq_one_input(outs[0]), .ext_irq_two_input(outs[1]),
        .timer_two_ext_clock(outs[2]), .timer_three_ext_clock(outs[3]),
        .timer_four_ext_clock(outs[4]), .timer_five_ext_clock(outs[5]),
        .capture_one_input(outs[6]), .capture_two_input(outs[7]),
        .capture_three_input(outs[8]), .capture_four_input(outs[9]),
        .capture_five_input(outs[10]), .compare_fault_a_input(outs[11]),
        .compare_fault_b_input(outs[12]), .serial_one_receive(outs[13]),
        .serial_one_clear_to_send(outs[14]), .serial_two_receive(outs[15]),
        .serial_two_clear_to_send(outs[16]), .spi_one_data_in(outs[17]),
        .spi_one_clock_in(outs[18]), .spi_one_select_in(outs[19]),
        .spi_two_data_in(outs[20]), .spi_two_clock_in(outs[21]),
        .spi_two_select_in(outs[22]), .mapping_lock_bit(lock), .mismatch_reset_req(mm));
    // ==========================================================
    // tasks
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("mismatch %s exp %h got %h", nm, e, g);
            error_cnt++;
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick
    // registered outputs read in the active region still show the pre-edge value
    task ahb(input logic w, input logic [31:0] ad, input logic [31:0] d);
        @(posedge mclk);
        hsel   <= 1'b1;
        haddr  <= ad;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task do_key(input logic [7:0] v);
        ahb(1'b1, 32'h80, 32'h46);
        ahb(1'b1, 32'h80, 32'h57);
        ahb(1'b1, 32'h80, {24'h0, v});
        tick(1);
    endtask : do_key
    task final_report;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    // ==========================================================
    // clock, watchdog and tests
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        #2000000;
        error_cnt++;
        final_report();
    end
    initial begin
        {rst_b, hsel, hwrite, htrans, haddr, hwdata, pin_want, ana} = '0;
        tick(3);
        rst_b    <= 1'b1;
        pin_want <= '1;
        tick(5);
        chk("outs after reset", 32'h0, {9'h0, outs});
        for (int i = 0; i < 23; i++) begin
            ahb(1'b0, {25'h0, FN_REG[i], 2'h0}, 32'h0);
            chk("route reset", 32'h1f1f, rd);
        end
        chk("lock reset", 32'h0, {31'h0, lock});
        $display("test reset done");
        for (int i = 0; i < 23; i++) begin
            p  = 5'((i * 11) % 26);
            a  = {25'h0, FN_REG[i], 2'h0};
            wd = FN_HI[i] ? {19'h0, p, 8'h1f} : {19'h0, 5'h1f, 3'h0, p};
            ahb(1'b1, a, wd);
            ahb(1'b0, a, 32'h0);
            chk("route readback", wd, rd);
            pin_want <= 26'h1 << p;
            tick(5);
            chk("routed high", 32'h1 << i, {9'h0, outs});
            pin_want <= ~(26'h1 << p);
            tick(5);
            chk("routed low", 32'h0, {9'h0, outs});
            ahb(1'b1, a, 32'h1f1f);
        end
        $display("test table done");
        pin_want <= '1;
        ahb(1'b1, 32'h0, 32'h1f19);
        tick(5);
        chk("top pin", 32'h1, {31'h0, outs[0]});
        ahb(1'b1, 32'h0, 32'h1f1a);
        tick(5);
        chk("absent pin", 32'h0, {31'h0, outs[0]});
        ahb(1'b1, 32'h0, 32'h1f04);
        ana <= 26'h10;
        tick(5);
        chk("analog claim", 32'h0, {31'h0, outs[0]});
        ana <= '1;
        tick(3);
        ana <= '0;
        tick(5);
        chk("digital again", 32'h1, {31'h0, outs[0]});
        $display("test boundary done");
        do_key(8'h40);
        chk("lock set", 32'h1, {31'h0, lock});
        ahb(1'b1, 32'h0, 32'h1f07);
        ahb(1'b0, 32'h0, 32'h0);
        chk("locked write", 32'h1f04, rd);
        ahb(1'b1, 32'h80, 32'h46);
        ahb(1'b1, 32'h04, 32'h1f1f);
        ahb(1'b1, 32'h80, 32'h57);
        ahb(1'b1, 32'h80, 32'h0);
        tick(1);
        chk("aborted key", 32'h1, {31'h0, lock});
        do_key(8'h00);
        chk("lock clear", 32'h0, {31'h0, lock});
        ahb(1'b1, 32'h0, 32'h1f03);
        ahb(1'b0, 32'h0, 32'h0);
        chk("unlocked write", 32'h1f03, rd);
        ahb(1'b1, 32'h08, 32'h1234);
        ahb(1'b0, 32'h08, 32'h0);
        chk("unmapped", 32'h0, rd);
        ahb(1'b0, 32'h84, 32'h0);
        chk("status", 32'h0, rd);
        chk("mismatch pin", 32'h0, {31'h0, mm});
        chk("response", 32'h0, {31'h0, hresp});
        $display("test lock done");
        do_key(8'h40);
        rst_b <= 1'b0;
        tick(2);
        rst_b <= 1'b1;
        ahb(1'b0, 32'h0, 32'h0);
        chk("route second reset", 32'h1f1f, rd);
        chk("lock second reset", 32'h0, {31'h0, lock});
        $display("test second reset done");
        final_report();
    end
endmodule : remappable_input_pin_select_bench
